// ### verilog/fbc_ctl.sv
/*
 bank 1 command control: control, address, erase counter and status registers on a
 classic wishbone slave, with the sequencer that launches flash commands.
 assumes the unlock key checks sit outside and report a correct key as a one-cycle
 pulse on this clock; flash array, shared ram and option byte inputs are on this clock.
*/
// Register access over Wishbone was chosen for this implementation.
module fbc_ctl (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bank1_unlock_ok,
	input wire logic option_unlock_ok,
	input wire logic fastprog_ram_ready,
	input wire logic basic_ram_ready,
	input wire logic eeprom_ram_ready,
	input wire logic [3:0] eeprom_size_cfg,
	input wire logic [3:0] eeprom_alloc_cfg,
	input wire logic eeprom_erase_done,
	input wire logic flash_ack,
	input wire logic flash_err,
	input wire logic flash_blank_fail,
	output logic flash_req,
	output logic [3:0] flash_cmd,
	output logic [31:0] flash_addr,
	output logic [7:0] flash_dwords,
	output logic [1:0] shared_ram_cmd,
	output logic option_reload_req,
	output logic option_write_enable,
	output logic ctl_lock_bit,
	output logic busy,
	output logic irq
);
	typedef struct packed {
		fbc_pkg::fbc_ctl_s ctl;
		logic [31:0] addr;
		logic [31:0] cnt;
		logic cnt_loaded;
		logic op_done_flag;
		logic fault_flag;
		logic blank_flag;
		logic ack;
		logic [31:0] rdata;
		logic launch;
		logic busy_q;
		logic reload;
	} fbc_top_s;

	fbc_top_s st;
	fbc_top_s next_st;

	logic [1:0] rst_sync;
	logic rst_n;
	logic seq_busy;
	logic done_p;
	logic fault_p;
	logic blank_p;
	fbc_pkg::fbc_cmd_e seq_cmd;
	fbc_pkg::fbc_cmd_e sel_cmd;
	logic req;
	logic wr;
	logic eep_valid;
	fbc_pkg::fbc_ctl_s wctl;

	// reset enters asynchronously, leaves through two flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	assign req = wb_cyc_i && wb_stb_i && !st.ack;
	// partial-word writes are dropped, not merged
	assign wr = req && wb_we_i && wb_sel_i == fbc_pkg::SEL_WORD;
	assign wctl = fbc_pkg::fbc_ctl_s'(wb_dat_i);
	assign eep_valid = eeprom_size_cfg != fbc_pkg::EEP_SIZE_NONE
		&& eeprom_alloc_cfg != fbc_pkg::EEP_SIZE_NONE;

	// one command at a time; the highest listed wins if several are set
	always_comb begin
		sel_cmd = fbc_pkg::CMD_NONE;
		if (st.ctl.blank_check_cmd) begin
			sel_cmd = fbc_pkg::CMD_BLANK_CHECK;
		end else if (st.ctl.opt0_erase_cmd) begin
			sel_cmd = fbc_pkg::CMD_OPT0_ERASE;
		end else if (st.ctl.opt0_program_cmd) begin
			sel_cmd = fbc_pkg::CMD_OPT0_PROGRAM;
		end else if (st.ctl.dataflash_bulk_erase_cmd) begin
			sel_cmd = fbc_pkg::CMD_DATA_BULK;
		end else if (st.ctl.main_bulk_erase_cmd) begin
			sel_cmd = fbc_pkg::CMD_MAIN_BULK;
		end else if (st.ctl.page_erase_cmd) begin
			sel_cmd = fbc_pkg::CMD_PAGE_ERASE;
		end else if (st.ctl.fast_program_cmd) begin
			sel_cmd = fbc_pkg::CMD_FAST_PROGRAM;
		end else if (st.ctl.program_cmd) begin
			sel_cmd = fbc_pkg::CMD_PROGRAM;
		end
	end

	always_comb begin
		next_st = st;
		next_st.launch = 1'b0;
		next_st.reload = 1'b0;
		next_st.busy_q = seq_busy;
		next_st.ack = req;

		// hardware clears; a software write in the same cycle overrides the shared ram clear, not the start clear
		if (fastprog_ram_ready || basic_ram_ready || eeprom_ram_ready) begin
			next_st.ctl.shared_ram_cmd = fbc_pkg::SRAM_NOP;
		end
		if (st.busy_q && !seq_busy) begin
			next_st.ctl.start = 1'b0;
		end

		if (req) begin
			unique case (wb_adr_i)
				fbc_pkg::OFS_CTL: next_st.rdata = st.ctl;
				fbc_pkg::OFS_ADDR: next_st.rdata = st.addr;
				fbc_pkg::OFS_CNT: next_st.rdata = st.cnt;
				fbc_pkg::OFS_STAT: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rdata[fbc_pkg::STAT_BUSY] = seq_busy;
					next_st.rdata[fbc_pkg::STAT_FAULT] = st.fault_flag;
					next_st.rdata[fbc_pkg::STAT_DONE] = st.op_done_flag;
					next_st.rdata[fbc_pkg::STAT_BLANK] = st.blank_flag;
				end
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end

		if (wr && wb_adr_i == fbc_pkg::OFS_CTL) begin
			if (st.ctl.ctl_lock_bit) begin
				next_st.ctl.ctl_lock_bit = 1'b1;
			end else begin
				next_st.ctl.blank_check_len_exp = wctl.blank_check_len_exp;
				next_st.ctl.shared_ram_cmd = wctl.shared_ram_cmd;
				next_st.ctl.blank_check_cmd = wctl.blank_check_cmd;
				next_st.ctl.option_reload = wctl.option_reload;
				next_st.reload = wctl.option_reload;
				next_st.ctl.done_irq_enable = wctl.done_irq_enable;
				next_st.ctl.fault_irq_enable = wctl.fault_irq_enable;
				next_st.ctl.option_write_enable = st.ctl.option_write_enable
					& wctl.option_write_enable;
				next_st.ctl.fast_program_cmd = wctl.fast_program_cmd;
				next_st.ctl.ctl_lock_bit = wctl.ctl_lock_bit;
				next_st.ctl.opt0_erase_cmd = wctl.opt0_erase_cmd;
				next_st.ctl.opt0_program_cmd = wctl.opt0_program_cmd;
				next_st.ctl.dataflash_bulk_erase_cmd = wctl.dataflash_bulk_erase_cmd;
				next_st.ctl.main_bulk_erase_cmd = wctl.main_bulk_erase_cmd;
				next_st.ctl.page_erase_cmd = wctl.page_erase_cmd;
				next_st.ctl.program_cmd = wctl.program_cmd;
				// start only rises from software; a second start while busy is ignored
				if (wctl.start && !st.ctl.start && !seq_busy) begin
					next_st.ctl.start = 1'b1;
					next_st.launch = 1'b1;
				end
			end
		end

		if (wr && wb_adr_i == fbc_pkg::OFS_ADDR && !st.ctl.ctl_lock_bit) begin
			next_st.addr = wb_dat_i;
		end

		// correct key clears the lock unless software sets it in the same cycle
		if (bank1_unlock_ok && !(wr && wb_adr_i == fbc_pkg::OFS_CTL && wctl.ctl_lock_bit)) begin
			next_st.ctl.ctl_lock_bit = 1'b0;
		end
		if (option_unlock_ok) begin
			next_st.ctl.option_write_enable = 1'b1;
		end

		// sticky status flags: a new event wins over a write-one clear
		if (wr && wb_adr_i == fbc_pkg::OFS_STAT) begin
			if (wb_dat_i[fbc_pkg::STAT_DONE]) begin
				next_st.op_done_flag = 1'b0;
			end
			if (wb_dat_i[fbc_pkg::STAT_FAULT]) begin
				next_st.fault_flag = 1'b0;
			end
			if (wb_dat_i[fbc_pkg::STAT_BLANK]) begin
				next_st.blank_flag = 1'b0;
			end
		end
		if (done_p) begin
			next_st.op_done_flag = 1'b1;
		end
		if (fault_p) begin
			next_st.fault_flag = 1'b1;
		end
		if (blank_p) begin
			next_st.blank_flag = 1'b1;
		end

		// configuration is caught on the first enabled cycle after reset
		if (!st.cnt_loaded) begin
			next_st.cnt_loaded = 1'b1;
			next_st.cnt = eep_valid ? fbc_pkg::CNT_RESET_VALID
				: fbc_pkg::CNT_RESET_EMPTY;
		end else if (eeprom_erase_done && eep_valid) begin
			next_st.cnt = st.cnt + 32'h0000_0001;
		end

		// reserved fields always read zero
		next_st.ctl.rsv28 = 1'b0;
		next_st.ctl.rsv27 = 2'b00;
		next_st.ctl.rsv23 = 7'h00;
		next_st.ctl.rsv15 = 2'b00;
		next_st.ctl.rsv11 = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.ctl <= fbc_pkg::fbc_ctl_s'(fbc_pkg::CTL_RESET);
			st.addr <= fbc_pkg::ADDR_RESET;
			st.cnt <= fbc_pkg::CNT_RESET_VALID;
			st.cnt_loaded <= 1'b0;
			st.op_done_flag <= 1'b0;
			st.fault_flag <= 1'b0;
			st.blank_flag <= 1'b0;
			st.ack <= 1'b0;
			st.rdata <= 32'h0000_0000;
			st.launch <= 1'b0;
			st.busy_q <= 1'b0;
			st.reload <= 1'b0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	fbc_seq u_seq (
		.clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.launch(st.launch),
		.cmd(sel_cmd),
		.addr(st.addr),
		.blen(st.ctl.blank_check_len_exp),
		.flash_ack(flash_ack),
		.flash_err(flash_err),
		.flash_blank_fail(flash_blank_fail),
		.flash_req(flash_req),
		.flash_cmd(seq_cmd),
		.flash_addr(flash_addr),
		.flash_dwords(flash_dwords),
		.busy(seq_busy),
		.done_p(done_p),
		.fault_p(fault_p),
		.blank_p(blank_p)
	);

	assign flash_cmd = seq_cmd;
	assign busy = seq_busy;
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdata;
	assign shared_ram_cmd = st.ctl.shared_ram_cmd;
	assign option_reload_req = st.reload;
	assign option_write_enable = st.ctl.option_write_enable;
	assign ctl_lock_bit = st.ctl.ctl_lock_bit;
	assign irq = (st.op_done_flag && st.ctl.done_irq_enable)
		|| ((st.fault_flag || st.blank_flag) && st.ctl.fault_irq_enable);
endmodule

// ### verilog/fbc_pkg.sv
/*
 constants, register layouts and enumerations of the bank 1 command control block.
 assumes a single 50 MHz system clock and a classic wishbone register bus.
*/
// How it works
// - blank check reads two-to-the-field double words
// - shared ram field picks none, fast, basic, eeprom
// - any ram ready clears the shared ram field
// - blank check bit runs a page blank check
// - writing one forces an option byte reload
// - done interrupt enable gates completion interrupt
// - fault interrupt enable gates error interrupt
// - option key sets write enable; software clears
// - lock resets set; key clears; software sets
// - software sets start; cleared as busy drops
// - bits five and four select option commands
// - bit three selects data flash bulk erase
// - bit two selects main flash bulk erase
// - bit one selects page erase at address
// - bit zero selects normal main program
// - bit eight selects fast main program
// - address register supplies the command target address
// - erase counter resets by eeprom configuration validity
// - busy high during operation, low at end
// - done flag set on success, write-one clears
package fbc_pkg;
	localparam logic [7:0] OFS_CTL = 8'h50;
	localparam logic [7:0] OFS_ADDR = 8'h54;
	localparam logic [7:0] OFS_CNT = 8'h58;
	localparam logic [7:0] OFS_STAT = 8'h70;
	localparam logic [3:0] SEL_WORD = 4'hf;

	localparam logic [31:0] CTL_RESET = 32'h0000_0080;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	localparam logic [31:0] CNT_RESET_VALID = 32'h0000_0000;
	localparam logic [31:0] CNT_RESET_EMPTY = 32'h0fff_ffff;
	localparam logic [3:0] EEP_SIZE_NONE = 4'h0;

	// status register bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_FAULT = 2;
	localparam int STAT_DONE = 5;
	localparam int STAT_BLANK = 6;

	localparam logic [7:0] DWORDS_ONE = 8'h01;

	typedef struct packed {
		logic [2:0] blank_check_len_exp;
		logic rsv28;
		logic [1:0] rsv27;
		logic [1:0] shared_ram_cmd;
		logic [6:0] rsv23;
		logic blank_check_cmd;
		logic [1:0] rsv15;
		logic option_reload;
		logic done_irq_enable;
		logic rsv11;
		logic fault_irq_enable;
		logic option_write_enable;
		logic fast_program_cmd;
		logic ctl_lock_bit;
		logic start;
		logic opt0_erase_cmd;
		logic opt0_program_cmd;
		logic dataflash_bulk_erase_cmd;
		logic main_bulk_erase_cmd;
		logic page_erase_cmd;
		logic program_cmd;
	} fbc_ctl_s;

	typedef enum logic [1:0] {
		SRAM_NOP = 2'b00,
		SRAM_FAST = 2'b01,
		SRAM_BASIC = 2'b10,
		SRAM_EEPROM = 2'b11
	} fbc_sram_e;

	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_PROGRAM = 4'h1,
		CMD_FAST_PROGRAM = 4'h2,
		CMD_PAGE_ERASE = 4'h3,
		CMD_MAIN_BULK = 4'h4,
		CMD_DATA_BULK = 4'h5,
		CMD_OPT0_PROGRAM = 4'h6,
		CMD_OPT0_ERASE = 4'h7,
		CMD_BLANK_CHECK = 4'h8
	} fbc_cmd_e;

	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_RUN = 1'b1
	} fbc_seq_e;
endpackage

// ### verilog/fbc_seq.sv
/*
 operation sequencer: hands one command at a time to the flash array and reports its end.
 assumes the array holds flash_ack high for one cycle, with err and blank result beside it.
*/
module fbc_seq (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic launch,
	input wire fbc_pkg::fbc_cmd_e cmd,
	input wire logic [31:0] addr,
	input wire logic [2:0] blen,
	input wire logic flash_ack,
	input wire logic flash_err,
	input wire logic flash_blank_fail,
	output logic flash_req,
	output fbc_pkg::fbc_cmd_e flash_cmd,
	output logic [31:0] flash_addr,
	output logic [7:0] flash_dwords,
	output logic busy,
	output logic done_p,
	output logic fault_p,
	output logic blank_p
);
	typedef struct packed {
		fbc_pkg::fbc_seq_e state;
		fbc_pkg::fbc_cmd_e cmd;
		logic [31:0] addr;
		logic [7:0] dwords;
		logic done;
		logic fault;
		logic blank;
	} fbc_seq_s;

	fbc_seq_s st;
	fbc_seq_s next_st;

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.fault = 1'b0;
		next_st.blank = 1'b0;
		unique case (st.state)
			fbc_pkg::SEQ_IDLE: begin
				if (launch) begin
					next_st.state = fbc_pkg::SEQ_RUN;
					next_st.cmd = cmd;
					next_st.addr = addr;
					next_st.dwords = fbc_pkg::DWORDS_ONE << blen;
				end
			end
			fbc_pkg::SEQ_RUN: begin
				// no command selected: busy for one cycle, then a fault
				if (st.cmd == fbc_pkg::CMD_NONE) begin
					next_st.state = fbc_pkg::SEQ_IDLE;
					next_st.fault = 1'b1;
				end else if (flash_ack) begin
					next_st.state = fbc_pkg::SEQ_IDLE;
					next_st.done = ~flash_err;
					next_st.fault = flash_err;
					next_st.blank = flash_blank_fail && st.cmd == fbc_pkg::CMD_BLANK_CHECK;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{fbc_pkg::SEQ_IDLE, fbc_pkg::CMD_NONE, 32'h0000_0000, 8'h00, 1'b0, 1'b0, 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign busy = st.state == fbc_pkg::SEQ_RUN;
	assign flash_req = busy && st.cmd != fbc_pkg::CMD_NONE;
	assign flash_cmd = st.cmd;
	assign flash_addr = st.addr;
	assign flash_dwords = st.dwords;
	assign done_p = st.done;
	assign fault_p = st.fault;
	assign blank_p = st.blank;
endmodule

// ### test/fbc_checker.sv
/*
 port checks for fbc_ctl, bound into every instance.
 assumes requests only after the internal reset copy releases, ce high.
*/
module fbc_checker (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic bank1_unlock_ok,
	input wire logic option_unlock_ok,
	input wire logic fastprog_ram_ready,
	input wire logic basic_ram_ready,
	input wire logic eeprom_ram_ready,
	input wire logic flash_ack,
	input wire logic flash_req,
	input wire logic [3:0] flash_cmd,
	input wire logic [31:0] flash_addr,
	input wire logic [7:0] flash_dwords,
	input wire logic [1:0] shared_ram_cmd,
	input wire logic option_reload_req,
	input wire logic option_write_enable,
	input wire logic ctl_lock_bit,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	logic wr_now;
	logic rdy;
	assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i;
	assign rdy = fastprog_ram_ready || basic_ram_ready || eeprom_ram_ready;
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack; s_req |=> s_ans; endproperty
	property p_lock; ctl_lock_bit && !bank1_unlock_ok && ce |=> ctl_lock_bit; endproperty
	property p_unlk; bank1_unlock_ok && ce && !wr_now |=> !ctl_lock_bit; endproperty
	property p_owe; option_unlock_ok && ce |=> option_write_enable; endproperty
	property p_owe_hw; !option_write_enable && !option_unlock_ok |=> !option_write_enable; endproperty
	property p_ram; rdy && ce && !wr_now |=> shared_ram_cmd == 2'b00; endproperty
	property p_len; flash_req |-> $onehot(flash_dwords); endproperty
	property p_hold; flash_req && !flash_ack && ce |=> flash_req && $stable(flash_addr)
		&& $stable(flash_cmd); endproperty
	property p_end; flash_req && flash_ack && ce |=> !busy && !flash_req; endproperty
	property p_rld; option_reload_req && ce |=> !option_reload_req; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	a_lock: assert property (p_lock) else $error("lock dropped");
	a_unlk: assert property (p_unlk) else $error("lock kept");
	a_owe: assert property (p_owe) else $error("owe not set");
	a_owe_hw: assert property (p_owe_hw) else $error("owe set by bus");
	a_ram: assert property (p_ram) else $error("ram cmd kept");
	a_len: assert property (p_len) else $error("dwords");
	a_hold: assert property (p_hold) else $error("req moved");
	a_end: assert property (p_end) else $error("busy kept");
	a_rld: assert property (p_rld) else $error("reload long");
endmodule

bind fbc_ctl fbc_checker u_chk (.sys_clk, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_ack_o, .bank1_unlock_ok, .option_unlock_ok, .fastprog_ram_ready, .basic_ram_ready,
	.eeprom_ram_ready, .flash_ack, .flash_req, .flash_cmd, .flash_addr, .flash_dwords,
	.shared_ram_cmd, .option_reload_req, .option_write_enable, .ctl_lock_bit, .busy);

// ### test/fbc_flash_model.sv
/*
 flash array stand-in: answers each request after a chosen wait.
 assumes flash_req holds until the ack edge.
*/
module fbc_flash_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flash_req,
	input wire logic [3:0] wait_cycles,
	input wire logic err_in,
	output logic flash_ack,
	output logic flash_err,
	output logic flash_blank_fail
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic junk;
	logic go;
	// result lines mean nothing away from ack, so they toggle there
	assign flash_err = flash_ack ? err_in : junk;
	// an error also reports a non-blank page; the design keeps it only for blank check
	assign flash_blank_fail = flash_ack ? err_in : ~junk;
	assign go = flash_req && !flash_ack;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			junk <= 1'b0;
			flash_ack <= 1'b0;
		end else begin
			junk <= ~junk;
			flash_ack <= go && cnt == wait_cycles;
			cnt <= (go && cnt != wait_cycles) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// ### test/tb.sv
/*
 self-checking bench for fbc_ctl with the flash array model on its far side.
 assumes ce high throughout; inputs change by nba at the rising edge.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0, err_in = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0, rnd = 32'h87c2, q, c, cap_adr;
	logic [5:0] ev = 6'h0;
	logic [3:0] cfg = 4'h3, dly = 4'h0, sel = 4'hf, cap_cmd, flash_cmd;
	logic [7:0] cap_dw, flash_dwords;
	logic [31:0] wb_dat_o, flash_addr;
	logic [1:0] shared_ram_cmd;
	logic wb_ack_o, flash_req, option_reload_req, option_write_enable, ctl_lock_bit, busy, irq;
	logic flash_ack, flash_err, flash_blank_fail;
	int miscompares = 0, comparisons = 0, cycles = 0, reloads = 0, exp_rl = 0, n;
	int bp[8] = '{0, 8, 1, 2, 3, 4, 5, 16};
	fbc_ctl dut (.sys_clk, .rstn, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
		.bank1_unlock_ok(ev[0]), .option_unlock_ok(ev[1]), .fastprog_ram_ready(ev[2]),
		.basic_ram_ready(ev[3]), .eeprom_ram_ready(ev[4]), .eeprom_size_cfg(cfg),
		.eeprom_alloc_cfg(cfg), .eeprom_erase_done(ev[5]), .flash_ack, .flash_err,
		.flash_blank_fail, .flash_req, .flash_cmd, .flash_addr, .flash_dwords, .shared_ram_cmd,
		.option_reload_req, .option_write_enable, .ctl_lock_bit, .busy, .irq);
	fbc_flash_model u_flash (.clk(sys_clk), .rst_n(rstn), .flash_req, .wait_cycles(dly),
		.err_in, .flash_ack, .flash_err, .flash_blank_fail);
	always #10 sys_clk = ~sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic results();
		if (miscompares == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// the master never counts on a latency: it waits for ack
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		if (wb_ack_o !== 1'b1) miscompares++;
		q = wb_dat_o;
		cyc <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		xf(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic pulse(input logic [5:0] m);
		ev <= m;
		@(posedge sys_clk);
		ev <= 6'h0;
		@(posedge sys_clk);
	endtask
	task automatic do_reset(input logic [3:0] v);
		rstn <= 1'b0;
		cfg <= v;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (option_reload_req === 1'b1) reloads++;
		if (flash_req === 1'b1) begin
			cap_cmd <= flash_cmd;
			cap_adr <= flash_addr;
			cap_dw <= flash_dwords;
		end
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		do_reset(4'h3);
		rc(8'h50, 32'h80, "ctl_rst");
		rc(8'h54, 32'h0, "adr_rst");
		rc(8'h58, 32'h0, "cnt_valid");
		xf(1'b1, 8'h50, 32'h1000);
		xf(1'b1, 8'h54, 32'h1234);
		rc(8'h50, 32'h80, "ctl_locked");
		rc(8'h54, 32'h0, "adr_locked");
		pulse(6'h01);
		chk("lock", 32'h0, ctl_lock_bit);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			c = (k == 0) ? 32'he000_3400 : rnd & 32'he000_3400;
			exp_rl += c[13];
			xf(1'b1, 8'h50, c | 32'h200);
			rc(8'h50, c, "ctl_rw");
		end
		chk("reloads", exp_rl, reloads);
		pulse(6'h02);
		chk("owe", 32'h1, option_write_enable);
		xf(1'b1, 8'h50, 32'h0);
		chk("owe_clr", 32'h0, option_write_enable);
		for (int j = 1; j < 4; j++) begin
			xf(1'b1, 8'h50, 32'(j) << 24);
			chk("sram", 32'(j), shared_ram_cmd);
			pulse(6'h02 << j);
			chk("sram_clr", 32'h0, shared_ram_cmd);
		end
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			dly <= rnd[3:0];
			err_in <= (i == 3 || i == 7);
			xf(1'b1, 8'h54, rnd);
			c = (32'h1 << bp[i]) | ((i == 0) ? 32'h0 : 32'h1400) | 32'h40 | {rnd[31:29], 29'h0};
			xf(1'b1, 8'h50, c);
			n = 0;
			while (busy !== 1'b0 && n < 60) begin
				@(posedge sys_clk);
				n++;
			end
			if (busy !== 1'b0) miscompares++;
			repeat (2) @(posedge sys_clk);
			chk("cmd", 32'(i + 1), cap_cmd);
			chk("adr", rnd, cap_adr);
			chk("dwords", 32'h1 << rnd[31:29], cap_dw);
			rc(8'h50, c & ~32'h40, "start_clr");
			rc(8'h70, (i == 3) ? 32'h4 : (i == 7) ? 32'h44 : 32'h20, "stat");
			chk("irq", 32'(i != 0), irq);
			xf(1'b1, 8'h70, 32'h64);
			xf(1'b1, 8'h50, 32'h0);
			chk("irq_clr", 32'h0, irq);
		end
		xf(1'b1, 8'h50, 32'h40);
		repeat (3) @(posedge sys_clk);
		rc(8'h70, 32'h4, "no_cmd");
		rc(8'h50, 32'h0, "no_cmd_start");
		xf(1'b1, 8'h70, 32'h64);
		sel <= 4'h3;
		xf(1'b1, 8'h54, 32'hdead_beef);
		sel <= 4'hf;
		rc(8'h54, rnd, "sel_drop");
		repeat (3) pulse(6'h20);
		rc(8'h58, 32'h3, "cnt");
		rc(8'h7c, 32'h0, "unmapped");
		xf(1'b1, 8'h50, 32'h80);
		chk("lock_set", 32'h1, ctl_lock_bit);
		xf(1'b1, 8'h50, 32'h1000);
		rc(8'h50, 32'h80, "relock");
		do_reset(4'h0);
		pulse(6'h20);
		rc(8'h58, 32'h0fff_ffff, "cnt_empty");
		results();
	end
endmodule
